// >>> hw/port0_external_memory_addressing.sv
// port 0 high address / nibble i/o, handshake and external memory bus control
// ************************
// Notes on behaviour
// ************************
// Notes on behaviour
// RL1: port 0 nibbles separately i/o or address
// RL2: handshake uses port 3 lines 2 and 5
// RL3: upper nibble direction picks handshake roles
// RL4: lower nibble handshakes only with matching direction
// RL5: lower nibble A11-A8, both A15-A8
// RL6: upper nibble may be i/o alone
// RL7: nibble becomes i/o only by mode write
// RL8: external-program reset: address nibbles, extended timing
// RL9: software may turn extended timing off
// RL10: lowest twelve bytes hold six vectors
// RL11: on-chip mode fetches internal below boundary
// RL12: external-program mode 16-bit program address
// RL13: fetch starts at 000C after reset
// RL14: data memory mapped above boundary or full
// RL15: optional data space select on port 3 line 4
// RL16: select high for constants, low for external loads
// RL17: address nibbles held through whole bus cycle
// RL18: external memory decodes data space by select
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "p0x_regs.svh"
module port0_external_memory_addressing
    import p0x_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_program_mode_pin,
    input wire logic core_req_valid,
    output logic core_req_ready,
    input wire access_kind_t core_req_kind,
    input wire logic [15:0] core_req_addr,
    output logic core_rsp_valid,
    output logic core_rsp_internal,
    output logic core_rsp_vector,
    output logic [7:0] core_rsp_data,
    output logic [15:0] boot_pc,
    output logic [7:0] ext_addr_lo,
    output logic ext_strobe_n,
    input wire logic [7:0] ext_data_in,
    input wire logic [7:0] p0_in,
    output logic [7:0] p0_out,
    output logic [7:0] p0_oe,
    input wire logic p32_in,
    output logic p32_out,
    output logic p32_oe,
    input wire logic p35_in,
    output logic p35_out,
    output logic p35_oe,
    output logic data_space_select_n,
    output logic data_space_select_oe
);
    // ************************
    // pin synchronisers
    // ************************
    logic [18:0] sync1_q;
    logic [18:0] sync2_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 19'h7FFFF;
            sync2_q <= 19'h7FFFF;
        end else begin
            sync1_q <= {external_program_mode_pin, p35_in, p32_in, ext_data_in, p0_in};
            sync2_q <= sync1_q;
        end
    end
    logic strap_s;
    logic ready_in_s;
    logic dav_in_n_s;
    logic [7:0] ext_data_s;
    logic [7:0] p0_in_s;
    assign {strap_s, ready_in_s, dav_in_n_s, ext_data_s, p0_in_s} = sync2_q;

    // ************************
    // strap capture after reset release
    // ************************
    // the strap needs the synchroniser filled, so it is caught a few edges late
    logic [1:0] settle_q;
    logic boot_done_q;
    logic ext_mode_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_q <= 2'h0;
            boot_done_q <= 1'b0;
            ext_mode_q <= 1'b0;
        end else if (!boot_done_q) begin
            settle_q <= settle_q + 2'h1;
            if (settle_q == `P0X_STRAP_SETTLE) begin
                boot_done_q <= 1'b1;
                ext_mode_q <= strap_s;
            end
        end
    end
    assign boot_pc = `P0X_RESET_PC; // [RL13]

    // ************************
    // register file
    // ************************
    logic [4:0] mode_q;
    logic [1:0] cfg_q;
    logic [7:0] p0_data_q;
    logic [7:0] p0_latch_q;
    logic hs_pending_q;
    logic aw_have_q;
    logic w_have_q;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic wr_ok;
    logic data_wr;
    logic data_rd;
    bus_state_t st_q;
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_ok = (aw_addr_q == `P0X_OFF_MODE) || (aw_addr_q == `P0X_OFF_BUSCFG)
        || (aw_addr_q == `P0X_OFF_DATA);
    assign data_wr = wr_fire && (aw_addr_q == `P0X_OFF_DATA) && w_strb_q[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[3:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // nibbles leave address duty only through this write [RL7]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= `P0X_MODE_RESET;
            cfg_q <= `P0X_CFG_RESET;
            p0_data_q <= 8'h00;
        end else if (!boot_done_q) begin
            mode_q <= `P0X_MODE_RESET; // [RL8]
            cfg_q[`P0X_CFG_EXT_TIMING] <= strap_s; // [RL8]
        end else if (wr_fire && w_strb_q[0]) begin
            if (aw_addr_q == `P0X_OFF_MODE) begin
                mode_q <= w_data_q[4:0]; // [RL1] [RL6]
            end
            if (aw_addr_q == `P0X_OFF_BUSCFG) begin
                cfg_q <= w_data_q[1:0]; // [RL9] [RL15]
            end
            if (aw_addr_q == `P0X_OFF_DATA) begin
                p0_data_q <= w_data_q[7:0];
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case ({s_axi_araddr[3:2], 2'h0})
                `P0X_OFF_MODE: s_axi_rdata <= {27'h0, mode_q};
                `P0X_OFF_BUSCFG: s_axi_rdata <= {30'h0, cfg_q};
                `P0X_OFF_DATA: s_axi_rdata <= {24'h0, p0_latch_q};
                `P0X_OFF_STATUS: s_axi_rdata <= {28'h0, st_q != ST_IDLE,
                    LARGE_VARIANT, hs_pending_q, ext_mode_q};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
    assign data_rd = s_axi_arvalid && s_axi_arready && (s_axi_araddr[3:2] == 2'h2);

    // ************************
    // port 0 handshake
    // ************************
    logic lo_io;
    logic hi_io;
    logic hi_out;
    logic hs_active;
    assign lo_io = mode_q[`P0X_MODE_LO_IO];
    assign hi_io = mode_q[`P0X_MODE_HI_IO];
    assign hi_out = mode_q[`P0X_MODE_HI_OUT];
    assign hs_active = mode_q[`P0X_MODE_HS_EN] && hi_io && lo_io
        && (mode_q[`P0X_MODE_LO_OUT] == hi_out); // [RL4]
    // output: data written raises data-available until the far end signals ready;
    // input: ready stays up until data-available latches a byte, a read reopens it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_pending_q <= 1'b0;
            p0_latch_q <= 8'h00;
        end else if (!hs_active) begin
            hs_pending_q <= 1'b0;
            p0_latch_q <= p0_in_s;
        end else if (hi_out) begin
            if (data_wr) begin
                hs_pending_q <= 1'b1;
            end else if (ready_in_s) begin
                hs_pending_q <= 1'b0;
            end
        end else begin
            if (!hs_pending_q && !dav_in_n_s) begin
                hs_pending_q <= 1'b1;
                p0_latch_q <= p0_in_s;
            end else if (data_rd) begin
                hs_pending_q <= 1'b0;
            end
        end
    end
    // roles of the two port 3 lines follow the upper nibble direction [RL2] [RL3]
    assign p32_oe = hs_active && hi_out;
    assign p32_out = !hs_pending_q;
    assign p35_oe = hs_active && !hi_out;
    assign p35_out = !hs_pending_q;

    // ************************
    // external bus cycle
    // ************************
    logic [15:0] addr_q;
    logic data_sel_q;
    access_kind_t kind_q;
    logic timer_start;
    logic timer_done;
    mem_map_if map_bus ();
    assign map_bus.addr = core_req_addr;
    assign map_bus.kind = core_req_kind;
    assign map_bus.external_program_mode = ext_mode_q;
    assign map_bus.large_variant = LARGE_VARIANT;
    mem_map u_map (
        .m(map_bus.map)
    );
    assign core_req_ready = (st_q == ST_IDLE) && boot_done_q;
    assign timer_start = core_req_valid && core_req_ready && map_bus.is_external;
    bus_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(timer_start),
        .extended(cfg_q[`P0X_CFG_EXT_TIMING]),
        .done(timer_done)
    );
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_IDLE;
            addr_q <= 16'h0000;
            kind_q <= ACC_FETCH;
            data_sel_q <= 1'b0;
            core_rsp_valid <= 1'b0;
            core_rsp_internal <= 1'b0;
            core_rsp_vector <= 1'b0;
            core_rsp_data <= 8'h00;
        end else begin
            core_rsp_valid <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (core_req_valid && core_req_ready) begin
                        addr_q <= core_req_addr; // [RL12]
                        kind_q <= core_req_kind;
                        data_sel_q <= map_bus.data_space;
                        core_rsp_vector <= map_bus.in_vector_area; // [RL10]
                        if (map_bus.is_external) begin
                            st_q <= ST_BUS;
                        end else begin
                            st_q <= ST_DONE; // [RL11]
                        end
                    end
                end
                ST_BUS: begin
                    if (timer_done) begin
                        core_rsp_data <= ext_data_s;
                        core_rsp_internal <= 1'b0;
                        core_rsp_valid <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
                ST_DONE: begin
                    // internal memory contents live in the core, only the hit is flagged
                    core_rsp_data <= 8'h00;
                    core_rsp_internal <= 1'b1;
                    core_rsp_valid <= 1'b1;
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    assign ext_addr_lo = addr_q[7:0];
    assign ext_strobe_n = (st_q != ST_BUS);
    // select only while a data load is on the bus, stays high for constants [RL16]
    assign data_space_select_oe = cfg_q[`P0X_CFG_DSS_EN]; // [RL15]
    assign data_space_select_n = !((st_q == ST_BUS) && data_sel_q);

    // ************************
    // port 0 nibble drivers
    // ************************
    // address nibbles keep the latched address through the whole cycle [RL17]
    for (genvar n = 0; n < 2; n++) begin : g_nib
        always_comb begin
            if (!mode_q[`P0X_MODE_LO_IO + n]) begin
                p0_out[4*n +: 4] = addr_q[8 + 4*n +: 4]; // [RL5]
                p0_oe[4*n +: 4] = 4'hF;
            end else begin
                p0_out[4*n +: 4] = p0_data_q[4*n +: 4]; // [RL6]
                p0_oe[4*n +: 4] = {4{mode_q[`P0X_MODE_LO_OUT + n]}};
            end
        end
    end

    // ************************
    // checks
    // ************************
    sequence s_strobe_normal;
        (!ext_strobe_n)[*3] ##1 ext_strobe_n;
    endsequence
    property p_dss_ldc;
        @(posedge aclk) disable iff (!aresetn)
        (kind_q != ACC_LOAD_EXTERNAL) |-> data_space_select_n;
    endproperty
    a_dss_ldc: assert property (p_dss_ldc) else $error("select low on non data access"); // [RL16]
    property p_dss_lde;
        @(posedge aclk) disable iff (!aresetn)
        (timer_start && core_req_kind == ACC_LOAD_EXTERNAL) |=> !data_space_select_n;
    endproperty
    a_dss_lde: assert property (p_dss_lde) else $error("select not low on data load"); // [RL16]
    property p_lo_addr;
        @(posedge aclk) disable iff (!aresetn)
        (!ext_strobe_n && !lo_io) |-> (p0_out[3:0] == addr_q[11:8]) && (p0_oe[3:0] == 4'hF);
    endproperty
    a_lo_addr: assert property (p_lo_addr) else $error("lower nibble not A11-A8"); // [RL5]
    property p_hi_addr;
        @(posedge aclk) disable iff (!aresetn)
        (!ext_strobe_n && !hi_io) |=> ext_strobe_n || hi_io
            || (p0_out[7:4] == $past(addr_q[15:12]));
    endproperty
    a_hi_addr: assert property (p_hi_addr) else $error("upper nibble not A15-A12"); // [RL17]
    property p_hs_dir;
        @(posedge aclk) disable iff (!aresetn)
        (p32_oe || p35_oe) |-> (p0_oe[3:0] == p0_oe[7:4]) && lo_io && hi_io;
    endproperty
    a_hs_dir: assert property (p_hs_dir) else $error("handshake with mixed nibbles"); // [RL4]
    property p_hs_roles;
        @(posedge aclk) disable iff (!aresetn)
        hs_active |-> (p32_oe == p0_oe[7]) && (p35_oe == !p0_oe[7]);
    endproperty
    a_hs_roles: assert property (p_hs_roles) else $error("handshake roles wrong"); // [RL3]
    property p_boot_cfg;
        @(posedge aclk) disable iff (!aresetn)
        $rose(boot_done_q) && ext_mode_q |-> cfg_q[`P0X_CFG_EXT_TIMING] && !lo_io && !hi_io;
    endproperty
    a_boot_cfg: assert property (p_boot_cfg) else $error("reset defaults wrong"); // [RL8]
    property p_internal;
        @(posedge aclk) disable iff (!aresetn)
        (core_req_valid && core_req_ready && !ext_mode_q
            && core_req_addr < (LARGE_VARIANT ? 16'h8000 : 16'h4000))
        |-> ##2 core_rsp_valid && core_rsp_internal && ext_strobe_n;
    endproperty
    a_internal: assert property (p_internal) else $error("internal fetch went out"); // [RL11]
    property p_bus_normal;
        @(posedge aclk) disable iff (!aresetn)
        (timer_start && !cfg_q[`P0X_CFG_EXT_TIMING]) |=> s_strobe_normal;
    endproperty
    a_bus_normal: assert property (p_bus_normal) else $error("normal cycle length"); // [RL9]
endmodule : port0_external_memory_addressing

// >>> hw/p0x_regs.svh
// register offsets, field positions, reset values and timing counts of the port 0 expansion bus
`ifndef P0X_REGS_SVH
`define P0X_REGS_SVH
// ************************
// register map (byte addresses)
// ************************
`define P0X_OFF_MODE 4'h0
`define P0X_OFF_BUSCFG 4'h4
`define P0X_OFF_DATA 4'h8
`define P0X_OFF_STATUS 4'hC
// ************************
// fields
// ************************
`define P0X_MODE_LO_IO 0
`define P0X_MODE_HI_IO 1
`define P0X_MODE_LO_OUT 2
`define P0X_MODE_HI_OUT 3
`define P0X_MODE_HS_EN 4
`define P0X_CFG_EXT_TIMING 0
`define P0X_CFG_DSS_EN 1
`define P0X_MODE_RESET 5'h00
`define P0X_CFG_RESET 2'h0
// ************************
// memory map
// ************************
`define P0X_VECTOR_BYTES 17'h0000C
`define P0X_RESET_PC 16'h000C
`define P0X_BOUNDARY_SMALL 17'h04000
`define P0X_BOUNDARY_LARGE 17'h08000
// ************************
// timing
// ************************
`define P0X_CLK_PERIOD_NS 10
`define P0X_BUS_NORMAL_NS 30
`define P0X_BUS_EXTENDED_NS 60
`define P0X_BUS_NORMAL_CYC ((`P0X_BUS_NORMAL_NS + `P0X_CLK_PERIOD_NS - 1) / `P0X_CLK_PERIOD_NS)
`define P0X_BUS_EXT_CYC ((`P0X_BUS_EXTENDED_NS + `P0X_CLK_PERIOD_NS - 1) / `P0X_CLK_PERIOD_NS)
`define P0X_STRAP_SETTLE 2'h3
`endif

// >>> hw/p0x_pkg.sv
// types shared by the port 0 expansion bus modules
package p0x_pkg;
    typedef enum logic [1:0] {
        ACC_FETCH,
        ACC_LOAD_CONSTANT,
        ACC_LOAD_EXTERNAL
    } access_kind_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUS,
        ST_DONE
    } bus_state_t;
endpackage : p0x_pkg

// >>> hw/mem_map_if.sv
// address decode request and answer between the bus controller and the map
`timescale 1ns/1ns
interface mem_map_if;
    import p0x_pkg::*;
    logic [15:0] addr;
    access_kind_t kind;
    logic external_program_mode;
    logic large_variant;
    logic is_external;
    logic in_vector_area;
    logic data_space;
    modport map (input addr, kind, external_program_mode, large_variant,
        output is_external, in_vector_area, data_space);
    modport user (output addr, kind, external_program_mode, large_variant,
        input is_external, in_vector_area, data_space);
endinterface : mem_map_if

// >>> hw/mem_map.sv
// program and data space decode
`timescale 1ns/1ns
`include "p0x_regs.svh"
module mem_map
    import p0x_pkg::*;
(
    mem_map_if.map m
);
    logic [16:0] boundary;
    logic [16:0] addr_w;
    always_comb begin
        boundary = m.large_variant ? `P0X_BOUNDARY_LARGE : `P0X_BOUNDARY_SMALL;
        addr_w = {1'b0, m.addr};
        // external-program mode sends the whole 64K of both spaces out [RL12] [RL14]
        if (m.external_program_mode) begin
            m.is_external = 1'b1;
        end else begin
            m.is_external = (addr_w >= boundary); // [RL11] [RL14]
        end
        m.in_vector_area = (addr_w < `P0X_VECTOR_BYTES); // [RL10]
        m.data_space = (m.kind == ACC_LOAD_EXTERNAL);
    end
endmodule : mem_map

// >>> hw/bus_timer.sv
// external bus cycle length counter, normal or extended
`timescale 1ns/1ns
`include "p0x_regs.svh"
module bus_timer #(
    parameter int NORMAL_CYC = `P0X_BUS_NORMAL_CYC,
    parameter int EXT_CYC = `P0X_BUS_EXT_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic extended,
    output logic done
);
    // the counter is eight bits wide and a cycle needs at least one strobe-low clock
    if (NORMAL_CYC < 1 || EXT_CYC < NORMAL_CYC || EXT_CYC > 255) begin : g_bad_counts
        $error("bus_timer: bad cycle counts");
    end
    logic [7:0] count_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 8'h00;
        end else if (start) begin
            count_q <= extended ? 8'(EXT_CYC - 1) : 8'(NORMAL_CYC - 1);
        end else if (count_q != 8'h00) begin
            count_q <= count_q - 8'h01;
        end
    end
    assign done = (count_q == 8'h00) && !start;
endmodule : bus_timer

// >>> verif/ext_mem_model.sv
// external program and data memory behind the port 0 address bus
`timescale 1ns/1ns
module ext_mem_model (
    input wire logic aclk,
    input wire logic ext_strobe_n,
    input wire logic [7:0] p0_out,
    input wire logic [7:0] ext_addr_lo,
    input wire logic data_space_select_n,
    output logic [7:0] ext_data_in
);
    logic [7:0] idle_q = 8'h3C;
    // ************************
    // memory answer
    // ************************
    // a released bus never shows the last byte, so a late sample is caught
    always @(posedge aclk) begin
        idle_q <= ~idle_q ^ 8'h5A;
    end
    // data space kept apart from program space by the select strobe
    assign ext_data_in = ext_strobe_n ? idle_q : ({p0_out[3:0], 4'h0} ^ ext_addr_lo
        ^ (data_space_select_n ? 8'h00 : 8'hFF));
endmodule : ext_mem_model

// >>> verif/port0_external_memory_addressing_tb.sv
// self-checking bench of the port 0 expansion bus block
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module port0_external_memory_addressing_tb
    import p0x_pkg::*;
;
    typedef struct {access_kind_t k; logic [15:0] a; logic on_chip; logic vec;} row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, external_program_mode_pin, core_req_valid, core_req_ready;
    logic core_rsp_valid, core_rsp_internal, core_rsp_vector, ext_strobe_n;
    logic p32_in, p32_out, p32_oe, p35_in, p35_out, p35_oe;
    logic data_space_select_n, data_space_select_oe, rsp_int, rsp_vec, sel_low;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    access_kind_t core_req_kind;
    logic [15:0] core_req_addr, boot_pc;
    logic [7:0] core_rsp_data, ext_addr_lo, ext_data_in, p0_in, p0_out, p0_oe;
    logic [7:0] bus_hi, bus_oe, rsp_data;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int n_low;
    row_t rows [9] = '{'{ACC_FETCH, 16'h0000, 1'b1, 1'b1}, '{ACC_FETCH, 16'h000B, 1'b1, 1'b1},
        '{ACC_FETCH, 16'h000C, 1'b1, 1'b0}, '{ACC_FETCH, 16'h3FFF, 1'b1, 1'b0},
        '{ACC_FETCH, 16'h4000, 1'b0, 1'b0}, '{ACC_LOAD_CONSTANT, 16'h4000, 1'b0, 1'b0},
        '{ACC_LOAD_EXTERNAL, 16'h4000, 1'b0, 1'b0}, '{ACC_LOAD_EXTERNAL, 16'hFFFF, 1'b0, 1'b0},
        '{ACC_LOAD_CONSTANT, 16'h8ABC, 1'b0, 1'b0}};
    port0_external_memory_addressing #(.LARGE_VARIANT(1'b0)) dut (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .external_program_mode_pin, .core_req_valid,
        .core_req_ready, .core_req_kind, .core_req_addr, .core_rsp_valid, .core_rsp_internal,
        .core_rsp_vector, .core_rsp_data, .boot_pc, .ext_addr_lo, .ext_strobe_n, .ext_data_in,
        .p0_in, .p0_out, .p0_oe, .p32_in, .p32_out, .p32_oe, .p35_in, .p35_out, .p35_oe,
        .data_space_select_n, .data_space_select_oe);
    ext_mem_model mem (.aclk, .ext_strobe_n, .p0_out, .ext_addr_lo, .data_space_select_n,
        .ext_data_in);
    // ************************
    // helpers
    // ************************
    function automatic logic [7:0] exp_byte(input logic [15:0] a, input logic load_external_instruction);
        return {a[11:8], 4'h0} ^ a[7:0] ^ (load_external_instruction ? 8'hFF : 8'h00);
    endfunction : exp_byte
    task automatic stop_test;
        if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        // requests are refused until boot is done, at the fourth edge
        repeat (6) @(posedge aclk);
    endtask : do_reset
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task automatic access(input access_kind_t k, input logic [15:0] a);
        core_req_kind <= k;
        core_req_addr <= a;
        core_req_valid <= 1'b1;
        do @(posedge aclk); while (!core_req_ready);
        core_req_valid <= 1'b0;
        n_low = 0;
        sel_low = 1'b0;
        repeat (20) begin
            @(negedge aclk);
            if (!ext_strobe_n) begin
                n_low++;
                bus_hi = p0_out;
                bus_oe = p0_oe;
                sel_low = sel_low | !data_space_select_n;
            end
            if (core_rsp_valid) break;
        end
        rsp_int = core_rsp_internal;
        rsp_vec = core_rsp_vector;
        rsp_data = core_rsp_data;
        @(posedge aclk);
    endtask : access
    // ************************
    // clock, timeout and sequence
    // ************************
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, external_program_mode_pin, core_req_valid} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, core_req_addr} = '0;
        core_req_kind = ACC_FETCH;
        s_axi_wstrb = 4'hF;
        p0_in = 8'h5A;
        p32_in = 1'b1;
        p35_in = 1'b0;
        do_reset();
        `CHK(boot_pc, 16'h000C)
        axi_rd(4'h0);
        `CHK(rd[4:0], 5'h00)
        axi_wr(4'h4, 32'h2);
        `CHK(resp, 2'b00)
        `CHK(data_space_select_oe, 1'b1)
        foreach (rows[i]) begin
            access(rows[i].k, rows[i].a);
            `CHK(rsp_int, rows[i].on_chip)
            `CHK(rsp_vec, rows[i].vec)
            `CHK(n_low, rows[i].on_chip ? 0 : 3)
            `CHK(sel_low, !rows[i].on_chip && rows[i].k == ACC_LOAD_EXTERNAL)
            if (!rows[i].on_chip) `CHK({bus_oe, bus_hi}, {8'hFF, rows[i].a[15:8]})
            `CHK(rsp_data, rows[i].on_chip ? 8'h00 :
                exp_byte(rows[i].a, rows[i].k == ACC_LOAD_EXTERNAL))
        end
        axi_wr(4'h0, 32'h2);
        access(ACC_FETCH, 16'h4ABC);
        `CHK(bus_oe, 8'h0F)
        `CHK(bus_hi[3:0], 4'hA)
        `CHK(rsp_data, exp_byte(16'h4ABC, 1'b0))
        // handshake, output direction: a data write raises data-available until ready
        axi_wr(4'h0, 32'h1F);
        axi_wr(4'h8, 32'hA5);
        `CHK({p32_oe, p35_oe, p32_out, p0_oe, p0_out}, {3'h4, 16'hFFA5})
        p35_in <= 1'b1;
        repeat (4) @(posedge aclk);
        `CHK(p32_out, 1'b1)
        axi_wr(4'h0, 32'h1B);
        `CHK({p32_oe, p35_oe}, 2'h0)
        // input direction: data-available latches the port, a data read reopens ready
        axi_wr(4'h0, 32'h13);
        `CHK({p32_oe, p35_oe, p35_out}, 3'h3)
        p32_in <= 1'b0;
        repeat (4) @(posedge aclk);
        p32_in <= 1'b1;
        repeat (4) @(posedge aclk);
        axi_rd(4'hC);
        `CHK({rd[3:0], p35_out}, 5'h04)
        axi_rd(4'h8);
        `CHK({rd[7:0], p35_out}, 9'h0B5)
        external_program_mode_pin <= 1'b1;
        do_reset();
        access(ACC_FETCH, 16'h0100);
        `CHK(rsp_int, 1'b0)
        `CHK(n_low, 6)
        `CHK({bus_oe, bus_hi}, 16'hFF01)
        axi_wr(4'h4, 32'h0);
        access(ACC_LOAD_EXTERNAL, 16'h0123);
        `CHK(n_low, 3)
        `CHK(rsp_int, 1'b0)
        stop_test();
    end
endmodule : port0_external_memory_addressing_tb
